// [adcc_pkg.sv]
// Shared constants and carrier types for the converter control block.
// Assumes a 32-bit classic Wishbone bus and an analog core outside.
package adcc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h01E;
  localparam logic [9:0] IDX_CTRL_FIRST = 10'h01F;
  localparam logic [9:0] IDX_RESULT_LOW = 10'h09E;
  localparam logic [9:0] IDX_CONFIG = 10'h09F;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0A0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0A1;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;

  // Field positions and masks
  localparam int IRQ_CONV_BIT = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'hFD;
  localparam logic [7:0] CONFIG_WR_MASK = 8'hCF;
  localparam logic [7:0] IRQ_WR_MASK = 8'h01;
  localparam int RESULT_PAD = 6;

  // Conversion clock
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [6:0] DIV_2 = 7'h02;
  localparam logic [6:0] DIV_4 = 7'h04;
  localparam logic [6:0] DIV_8 = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;
  localparam logic [3:0] TAD_PER_CONV = 4'hC;

  // Software-visible fields of the first control register
  typedef struct packed {
    logic [1:0] conv_clk_sel_lo;
    logic [2:0] channel;
    logic start;
    logic rsvd;
    logic converter_power_on;
  } adcc_ctrl_t;

  // Fields of converter_config_reg
  typedef struct packed {
    logic result_format_sel;
    logic conv_clk_sel_hi;
    logic [1:0] rsvd;
    logic [3:0] port_config_field;
  } adcc_cfg_t;

  // Pin routing toward the port logic and reference muxes
  typedef struct packed {
    logic [7:0] analog_en;
    logic [7:0] digital_en;
    logic vref_pos_pin3;
    logic vref_neg_pin2;
  } adcc_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } adcc_state_t;

endpackage : adcc_pkg

// [adcc_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous inputs.
// Assumes inputs change slowly compared with the sampling clock.
module adcc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;

  // Stage one is read only by stage two
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= async_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a new level only when stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign level_o = lvl_ff;

endmodule : adcc_sync

// [adcc_top.sv]
// Converter control: config register, clock select, pin routing,
// conversion sequencing and result capture behind a Wishbone slave.
// Assumes an analog core that holds done and result until start drops.
//
// What this block and its software do
// R1: Right justify result when format bit set
// R2: Left justify result when format bit clear
// R3: Conversion clock from three select bits
// R4: Config bits 5 and 4 read zero
// R5: Decode port field into eight pin modes
// R6: Pick reference sources from port field
// R7: Digital pins to I/O, analog to converter
// R8: Reset forces shared pins to analog
// R9: Completion loads result, clears start, flags
// R10: Software waits acquisition before starting
// R11: Software sets analog pins as inputs
// R12: Software configures before powering and starting
// R13: Software clears flag before enabling interrupt
// R14: Software polls start flag or awaits interrupt
// R15: Hold capacitor never discharged between conversions
// R16: Start flag begins conversion when powered
// R17: Conversion spans at least twelve periods
// R18: Clearing start aborts, result unchanged
// R19: Synchronise RC-domain completion before use
module adcc_top
  import adcc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic rc_clk_i,
  input wire logic core_done_i,
  input wire logic [9:0] core_result_i,
  output logic core_start_o,
  output logic core_tad_o,
  output logic [2:0] core_channel_o,
  output logic core_power_o,
  output logic core_sample_o,
  output adcc_pins_t pin_route_o
);

  // Analog-pin mask for each port configuration code
  function automatic logic [7:0] analog_mask(input logic [3:0] code);
    logic [7:0] m;
    case (code)
      4'h0, 4'h1, 4'h8: m = 8'hFF;
      4'h2, 4'h3, 4'hC: m = 8'h1F;
      4'h4, 4'h5: m = 8'h0B;
      4'h6, 4'h7: m = 8'h00;
      4'h9, 4'hA, 4'hB: m = 8'h3F;
      4'hD: m = 8'h0F;
      4'hE: m = 8'h01;
      4'hF: m = 8'h0D;
      default: m = 8'hFF;
    endcase
    return m;
  endfunction : analog_mask
  // Positive reference comes from pin 3 for these codes
  function automatic logic vref_pos_ext(input logic [3:0] code);
    logic r;
    case (code)
      4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : vref_pos_ext
  // Negative reference comes from pin 2 for these codes
  function automatic logic vref_neg_ext(input logic [3:0] code);
    logic r;
    case (code)
      4'h8, 4'hB, 4'hC, 4'hD, 4'hF: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : vref_neg_ext
  // System clock divisor for one conversion period
  function automatic logic [6:0] tad_divisor(input logic hi, input logic [1:0] lo);
    logic [6:0] d;
    case ({hi, lo})
      3'h0: d = DIV_2;
      3'h1: d = DIV_8;
      3'h2: d = DIV_32;
      3'h4: d = DIV_4;
      3'h5: d = DIV_16;
      3'h6: d = DIV_64;
      default: d = DIV_2;
    endcase
    return d;
  endfunction : tad_divisor

  adcc_ctrl_t ctrl_ff;
  adcc_cfg_t cfg_ff;
  logic [7:0] res_hi_ff;
  logic [7:0] res_lo_ff;
  logic [7:0] irq_stat_ff;
  logic [7:0] irq_mask_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  adcc_state_t state_ff;
  adcc_state_t nxt_state;
  logic [6:0] div_cnt_ff;
  logic [3:0] tad_cnt_ff;
  logic rc_prev_ff;
  logic done_prev_ff;
  logic done_seen_ff;
  logic tad_tick;
  logic rc_lvl;
  logic done_lvl;
  logic done_rise;
  logic complete;
  logic abort;
  logic req;
  logic wr_stb;
  logic [9:0] idx;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [15:0] justified;
  logic [6:0] div_sel;
  logic use_rc;

  // Bus decode; a write lands at the edge where ack is sampled
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[11:2];
  assign wr_stb = req & wb_we_i & ack_ff & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // Asynchronous RC clock and completion level
  adcc_sync #(.WIDTH(2)) adcc_sync_inst (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .async_i({rc_clk_i, core_done_i}),
    .level_o({rc_lvl, done_lvl})
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc_prev_ff <= 1'b0;
      done_prev_ff <= 1'b0;
    end else begin
      rc_prev_ff <= rc_lvl;
      done_prev_ff <= done_lvl;
    end
  end
  assign done_rise = done_lvl & ~done_prev_ff; // R19

  // Conversion period source: divided system clock or RC edges
  assign use_rc = (ctrl_ff.conv_clk_sel_lo == CLK_SEL_RC); // R3
  assign div_sel = tad_divisor(cfg_ff.conv_clk_sel_hi, ctrl_ff.conv_clk_sel_lo); // R3

  // Divider restarts with each conversion so the first period is whole
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt_ff <= 7'h00;
    end else if (state_ff != ST_CONV) begin
      div_cnt_ff <= 7'h00;
    end else if (div_cnt_ff == div_sel - 7'h01) begin
      div_cnt_ff <= 7'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 7'h01;
    end
  end

  // One tick per conversion period
  assign tad_tick = use_rc ? (rc_lvl & ~rc_prev_ff) : // R3
                    (div_cnt_ff == div_sel - 7'h01);

  // Abort when start is written low or power removed mid-conversion
  assign abort = (state_ff != ST_IDLE) & wr_stb & (idx == IDX_CTRL_FIRST) &
                 (~wr_byte[2] | ~wr_byte[0]); // R18
  assign complete = (state_ff == ST_WAIT) & done_seen_ff & ~abort; // R9

  // Sequencer state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (ctrl_ff.start && ctrl_ff.converter_power_on) begin
          nxt_state = ST_CONV; // R16
        end
      end
      ST_CONV: begin
        if (abort) begin
          nxt_state = ST_IDLE; // R18
        end else if (tad_tick && tad_cnt_ff == TAD_PER_CONV - 4'h1) begin
          nxt_state = ST_WAIT; // R17
        end
      end
      ST_WAIT: begin
        if (abort || complete) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Count conversion periods; twelve must pass before completion
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tad_cnt_ff <= 4'h0;
    end else if (state_ff != ST_CONV) begin
      tad_cnt_ff <= 4'h0;
    end else if (tad_tick) begin
      tad_cnt_ff <= tad_cnt_ff + 4'h1; // R17
    end
  end

  // Latch the core's done edge for the running conversion only
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_seen_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      done_seen_ff <= 1'b0;
    end else if (done_rise) begin
      done_seen_ff <= 1'b1; // R19
    end
  end

  // First control register; hardware clears start at completion
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff <= adcc_ctrl_t'(CTRL_RST);
    end else if (wr_stb && idx == IDX_CTRL_FIRST) begin
      // Start only sticks when power was already on
      ctrl_ff <= adcc_ctrl_t'(wr_byte & CTRL_WR_MASK);
      ctrl_ff.start <= wr_byte[2] & wr_byte[0] & ctrl_ff.converter_power_on; // R16
    end else if (complete) begin
      ctrl_ff.start <= 1'b0; // R9
    end
  end

  // Config register; reset value makes every shared pin analog
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff <= adcc_cfg_t'(CONFIG_RST); // R8
    end else if (wr_stb && idx == IDX_CONFIG) begin
      cfg_ff <= adcc_cfg_t'(wr_byte & CONFIG_WR_MASK); // R4
    end
  end

  // Justify the raw result into the sixteen-bit pair
  assign justified = cfg_ff.result_format_sel ?
                     {{RESULT_PAD{1'b0}}, core_result_i} : // R1
                     {core_result_i, {RESULT_PAD{1'b0}}}; // R2

  // Result pair: loaded only on a finished conversion, else general purpose.
  // Core result is held stable until start drops, so no sync is needed.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      res_hi_ff <= RESULT_RST;
      res_lo_ff <= RESULT_RST;
    end else if (complete) begin
      res_hi_ff <= justified[15:8]; // R9
      res_lo_ff <= justified[7:0]; // R9
    end else if (wr_stb && idx == IDX_RESULT_HIGH) begin
      res_hi_ff <= wr_byte;
    end else if (wr_stb && idx == IDX_RESULT_LOW) begin
      res_lo_ff <= wr_byte;
    end
  end

  // Sticky status, write one to clear; a same-cycle set wins
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_ff <= IRQ_RST;
    end else begin
      if (wr_stb && idx == IDX_IRQ_STATUS) begin
        irq_stat_ff <= irq_stat_ff & ~(wr_byte & IRQ_WR_MASK);
      end
      if (complete) begin
        irq_stat_ff[IRQ_CONV_BIT] <= 1'b1; // R9
      end
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_ff <= IRQ_RST;
    end else if (wr_stb && idx == IDX_IRQ_MASK) begin
      irq_mask_ff <= wr_byte & IRQ_WR_MASK;
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff); // Level while any unmasked bit set

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (idx)
      IDX_CTRL_FIRST: rd_byte = ctrl_ff;
      IDX_CONFIG: rd_byte = cfg_ff & CONFIG_WR_MASK; // R4
      IDX_RESULT_HIGH: rd_byte = res_hi_ff;
      IDX_RESULT_LOW: rd_byte = res_lo_ff;
      IDX_IRQ_STATUS: rd_byte = irq_stat_ff;
      IDX_IRQ_MASK: rd_byte = irq_mask_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // One wait state: ack the cycle after the request, drop it after
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff) begin
        dat_ff <= {24'h00_0000, rd_byte};
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // Pin routing registered from the config field
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_route_o.analog_en <= 8'hFF; // R8
      pin_route_o.digital_en <= 8'h00; // R8
      pin_route_o.vref_pos_pin3 <= 1'b0;
      pin_route_o.vref_neg_pin2 <= 1'b0;
    end else begin
      pin_route_o.analog_en <= analog_mask(cfg_ff.port_config_field); // R5 R7
      pin_route_o.digital_en <= ~analog_mask(cfg_ff.port_config_field); // R7
      pin_route_o.vref_pos_pin3 <= vref_pos_ext(cfg_ff.port_config_field); // R6
      pin_route_o.vref_neg_pin2 <= vref_neg_ext(cfg_ff.port_config_field); // R6
    end
  end

  // Core controls. The sample switch tracks the channel whenever powered and idle;
  // there is no discharge path, so the held charge carries over.
  // Software must still allow acquisition time before starting.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      core_start_o <= 1'b0;
      core_tad_o <= 1'b0;
      core_channel_o <= 3'h0;
      core_power_o <= 1'b0;
      core_sample_o <= 1'b0;
    end else begin
      core_start_o <= (nxt_state != ST_IDLE); // R16
      // No period pulse on the edge that aborts, so none outlives start
      core_tad_o <= tad_tick & (state_ff == ST_CONV) & (nxt_state != ST_IDLE); // R17
      core_channel_o <= ctrl_ff.channel;
      core_power_o <= ctrl_ff.converter_power_on;
      core_sample_o <= ctrl_ff.converter_power_on & (nxt_state == ST_IDLE); // R15 R10
    end
  end

endmodule : adcc_top

// [adcc_monitor.sv]
// Checker for the converter control block, bound onto adcc_top.
// Assumes one clock domain; sees only the top module's ports.
module adcc_monitor
  import adcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_done_i,
  input wire logic core_start_o,
  input wire logic core_tad_o,
  input wire logic core_power_o,
  input wire adcc_pins_t pin_route_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] tad_cnt_ff;
  // Periods seen in the running conversion; cleared when start is low
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) tad_cnt_ff <= 8'h00;
    else if (!core_start_o) tad_cnt_ff <= 8'h00;
    else if (core_tad_o) tad_cnt_ff <= tad_cnt_ff + 8'h01;
  end
  // Completion steps: done arrives, start drops after the sync delay
  sequence s_done_seen;
    $rose(core_done_i) && core_start_o;
  endsequence
  sequence s_start_drop;
    ##[2:12] $fell(core_start_o);
  endsequence
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_pulse_only: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_reset_all_analog: assert property ($rose(nrst_i) |-> pin_route_o.analog_en == 8'hFF)
    else $error("pins not analog after reset");
  a_pin_mode_split: assert property (pin_route_o.analog_en == ~pin_route_o.digital_en)
    else $error("pin both or neither analog and digital");
  a_vref_neg_pair: assert property (pin_route_o.vref_neg_pin2 |-> pin_route_o.vref_pos_pin3)
    else $error("negative reference without positive");
  a_start_powered: assert property ($rose(core_start_o) |-> core_power_o)
    else $error("conversion started unpowered");
  a_tad_in_conv: assert property (core_tad_o |-> core_start_o)
    else $error("period pulse outside conversion");
  a_twelve_periods: assert property ($fell(core_start_o) && core_done_i |-> tad_cnt_ff >= 8'h0C)
    else $error("conversion shorter than twelve periods");
  a_done_ends_conv: assert property (s_done_seen |-> s_start_drop)
    else $error("start not cleared after completion");
  a_power_off_abort: assert property ($fell(core_power_o) |-> ##[0:2] !core_start_o)
    else $error("power off did not abort");
endmodule : adcc_monitor

bind adcc_top adcc_monitor adcc_monitor_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .core_done_i(core_done_i), .core_start_o(core_start_o), .core_tad_o(core_tad_o),
  .core_power_o(core_power_o), .pin_route_o(pin_route_o));

// [adcc_core_model.sv]
// Behavioural stand-in for the analog sample-and-hold and converter core.
// Assumes start is a level and tad a one-cycle pulse per period.
module adcc_core_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic tad_i,
  input wire logic [9:0] value_i,
  output logic done_o,
  output logic [9:0] result_o
);
  logic [3:0] per_ff = 4'h0;
  logic [3:0] lag_ff = 4'h0;
  initial done_o = 1'b0;
  initial result_o = 10'h000;
  // Count periods, then answer after a lag set by the value's top bits
  always @(posedge clk_i) begin
    if (!start_i) begin
      per_ff <= 4'h0;
      lag_ff <= 4'h0;
      done_o <= 1'b0;
      result_o <= ~result_o; // No stale value while idle
    end else if (per_ff < 4'hC) begin
      if (tad_i) per_ff <= per_ff + 4'h1;
    end else if (lag_ff < {value_i[9:8], 2'b00}) begin
      lag_ff <= lag_ff + 4'h1;
      result_o <= ~result_o;
    end else begin
      done_o <= 1'b1; // Held until start falls
      result_o <= value_i;
    end
  end
endmodule : adcc_core_model

// [adcc_tb_top.sv]
// Self-checking bench for adcc_top over classic Wishbone.
// Assumes a 100 MHz clock and a free-running RC oscillator stand-in.
module adcc_tb_top import adcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DMASK [16] = '{8'h00, 8'h00, 8'hE0, 8'hE0, 8'hF4, 8'hF4, 8'hFF,
    8'hFF, 8'h00, 8'hC0, 8'hC0, 8'hC0, 8'hE0, 8'hF0, 8'hFE, 8'hF2};
  localparam logic [15:0] VPOS = 16'hBD2A;
  localparam logic [15:0] VNEG = 16'hB900;
  logic clk = 1'b0, rc_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_w = 32'h0, dat_r;
  logic [9:0] core_val = 10'h000, res;
  logic ack, irq, done, start, bit_conversion_period, pwr, samp;
  logic [2:0] chan;
  adcc_pins_t route;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
  logic [7:0] q, hi, lo;
  // Clocks; the RC stand-in has a 170 ns period, its edges falling alternately on system clock rising and falling edges
  always #5 clk = ~clk;
  always #85 rc_clk = ~rc_clk;
  adcc_top adcc_top_inst (.ref_clk_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .irq_o(irq), .rc_clk_i(rc_clk), .core_done_i(done),
    .core_result_i(res), .core_start_o(start), .core_tad_o(bit_conversion_period), .core_channel_o(chan),
    .core_power_o(pwr), .core_sample_o(samp), .pin_route_o(route));
  adcc_core_model adcc_core_model_inst (.clk_i(clk), .start_i(start), .tad_i(bit_conversion_period),
    .value_i(core_val), .done_o(done), .result_o(res));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; the wait is bounded, a missing ack is a mismatch
  task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h000000, d};
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = dat_r[7:0];
    chk({7'h00, ack}, 8'h01);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(idx, 1'b1, d, 4'hF, r);
  endtask : wr
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    bus(idx, 1'b0, 8'h00, 4'hF, r);
    chk(r, exp);
  endtask : rd_chk
  // Full conversion; clock code cs, format cs[0], mask cs[2]
  task automatic conv(input logic [2:0] cs);
    logic [9:0] v;
    int n;
    v = {cs, 7'h4B};
    core_val <= v;
    wr(IDX_IRQ_STATUS, 8'h01);
    wr(IDX_IRQ_MASK, {7'h00, cs[2]});
    wr(IDX_CONFIG, {cs[0], cs[2], 6'h00});
    wr(IDX_CTRL_FIRST, {cs[1:0], 6'h29});
    repeat (20) @(posedge clk);
    wr(IDX_CTRL_FIRST, {cs[1:0], 6'h2D});
    repeat (2) @(posedge clk);
    chk({7'h00, start}, 8'h01);
    chk({7'h00, samp}, 8'h00);
    n = 0;
    q = 8'h04;
    while (q[2] && n < 500) begin
      bus(IDX_CTRL_FIRST, 1'b0, 8'h00, 4'hF, q);
      n++;
    end
    chk(q, {cs[1:0], 6'h29});
    chk({5'h00, chan}, 8'h05);
    chk({7'h00, samp}, 8'h01);
    hi = cs[0] ? {6'h00, v[9:8]} : v[9:2];
    lo = cs[0] ? v[7:0] : {v[1:0], 6'h00};
    rd_chk(IDX_RESULT_HIGH, hi);
    rd_chk(IDX_RESULT_LOW, lo);
    rd_chk(IDX_IRQ_STATUS, 8'h01);
    chk({7'h00, irq}, {7'h00, cs[2]});
    wr(IDX_IRQ_STATUS, 8'h01);
    rd_chk(IDX_IRQ_STATUS, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("conversion with clock code %0d done", cs);
  endtask : conv
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(IDX_RESULT_HIGH, RESULT_RST);
    rd_chk(IDX_IRQ_STATUS, IRQ_RST);
    rd_chk(IDX_CTRL_FIRST, CTRL_RST);
    rd_chk(IDX_CONFIG, CONFIG_RST);
    rd_chk(IDX_RESULT_LOW, RESULT_RST);
    rd_chk(IDX_IRQ_MASK, IRQ_RST);
    chk(route.analog_en, 8'hFF);
    $display("reset values done");
    wr(IDX_CONFIG, 8'hFF);
    rd_chk(IDX_CONFIG, 8'hCF);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_CONFIG, {4'h0, c[3:0]});
      repeat (2) @(posedge clk);
      chk(route.digital_en, DMASK[c]);
      chk({7'h00, route.vref_pos_pin3}, {7'h00, VPOS[c]});
      chk({7'h00, route.vref_neg_pin2}, {7'h00, VNEG[c]});
    end
    $display("port decode done");
    rd_chk(10'h3FF, 8'h00);
    bus(IDX_IRQ_MASK, 1'b1, 8'h01, 4'hE, q);
    rd_chk(IDX_IRQ_MASK, 8'h00);
    wr(IDX_CTRL_FIRST, 8'h04);
    rd_chk(IDX_CTRL_FIRST, 8'h00);
    $display("refusals done");
    for (int s = 0; s < 8; s++) conv(s[2:0]);
    wr(IDX_CTRL_FIRST, 8'hA9);
    repeat (20) @(posedge clk);
    wr(IDX_CTRL_FIRST, 8'hAD);
    repeat (100) @(posedge clk);
    wr(IDX_CTRL_FIRST, 8'h00);
    repeat (1000) @(posedge clk);
    rd_chk(IDX_RESULT_HIGH, hi);
    rd_chk(IDX_RESULT_LOW, lo);
    rd_chk(IDX_IRQ_STATUS, 8'h00);
    $display("abort done");
    final_report();
  end
endmodule : adcc_tb_top
